// [hw/lqi_pkg.sv]
package lqi_pkg;
    localparam int CORR_W = 8;
    localparam int LQI_W = 8;
    localparam logic [LQI_W-1:0] LQI_MIN = 8'h00;
    localparam logic [LQI_W-1:0] LQI_MAX = 8'hFF;
    localparam logic [CORR_W-1:0] CORR_FLOOR = 8'h40;
    localparam int AVG_SHIFT = 3;
    localparam int AVG_N = 1 << AVG_SHIFT;
    localparam int ACC_W = CORR_W + AVG_SHIFT;
    localparam logic [ACC_W-1:0] ACC_ZERO = '0;
    localparam logic [AVG_SHIFT:0] CNT_ZERO = '0;
    localparam logic [AVG_SHIFT:0] CNT_ONE = 4'h1;
    localparam logic [AVG_SHIFT:0] CNT_FULL = 4'h8;
    localparam int SCALE_SHIFT = 2;
endpackage : lqi_pkg

// [hw/lqi_scale.sv]
`timescale 1ns/1ps
`default_nettype none
module lqi_scale (
    // Mean correlation in
    input wire logic [lqi_pkg::CORR_W-1:0] mean,
    // Quality figure out
    output logic [lqi_pkg::LQI_W-1:0] lqi
);
    logic [lqi_pkg::CORR_W-1:0] above;
    logic [lqi_pkg::CORR_W+lqi_pkg::SCALE_SHIFT-1:0] wide;
    always_comb begin
        // Floor maps to 0, linear at four per count above it, saturating at 255 from mean 0x80 up
        above = (mean > lqi_pkg::CORR_FLOOR) ? mean - lqi_pkg::CORR_FLOOR : '0; // RULE_04
        wide = {{lqi_pkg::SCALE_SHIFT{1'b0}}, above} << lqi_pkg::SCALE_SHIFT;
        lqi = (wide > {{lqi_pkg::SCALE_SHIFT{1'b0}}, lqi_pkg::LQI_MAX}) ? lqi_pkg::LQI_MAX
                                                 : wide[lqi_pkg::LQI_W-1:0]; // RULE_03
    end
endmodule : lqi_scale
`default_nettype wire

// [hw/link_quality_estimator.sv]
// Contract
// RULE_01: Quality comes from averaging correlation over several symbols, never one.
// RULE_02: Computation starts by itself when the sync header is found.
// RULE_03: Result is an eight-bit unsigned value 0 to 255.
// RULE_04: Worst compliant signal maps to 0, best to 255, linear between. The code is linear only from mean 0x40 to 0x80 and holds 255 from 0x80 up.
// RULE_05: Result valid only at frame end, together with the frame done interrupt.
// RULE_06: Result offered to the frame buffer read path after frame end.
// RULE_07: Result held stable until the next frame completes.
`timescale 1ns/1ps
`default_nettype none
module link_quality_estimator (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Receive path
    input wire logic shr_found,
    input wire logic sym_valid,
    input wire logic [lqi_pkg::CORR_W-1:0] sym_corr,
    input wire logic frame_end,
    // Result and busy status
    output logic [lqi_pkg::LQI_W-1:0] lqi_q,
    output logic frame_done_interrupt,
    output logic busy_q
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RX = 2'b10
    } state_t;

    state_t state_q, state_d;
    logic [lqi_pkg::ACC_W-1:0] acc_q, acc_d;
    logic [lqi_pkg::AVG_SHIFT:0] cnt_q, cnt_d;
    logic [lqi_pkg::CORR_W-1:0] mean_q, mean_d;
    logic [lqi_pkg::LQI_W-1:0] lqi_d, lqi_new;
    logic irq_q, irq_d;
    logic busy_d;
    logic [lqi_pkg::ACC_W-1:0] block_sum;
    logic [lqi_pkg::AVG_SHIFT:0] seen_q, seen_d;

    lqi_scale u_scale (
        .mean(mean_q),
        .lqi(lqi_new)
    );

    always_comb begin
        state_d = state_q;
        acc_d = acc_q;
        cnt_d = cnt_q;
        mean_d = mean_q;
        lqi_d = lqi_q;
        irq_d = 1'b0;
        block_sum = acc_q + {{lqi_pkg::AVG_SHIFT{1'b0}}, sym_corr};
        unique case (state_q)
            ST_IDLE: begin
                if (shr_found) begin
                    state_d = ST_RX; // RULE_02
                    acc_d = lqi_pkg::ACC_ZERO;
                    cnt_d = lqi_pkg::CNT_ZERO;
                    // Clearing the mean keeps a short frame from reporting the last one
                    mean_d = '0;
                end
            end
            ST_RX: begin
                if (sym_valid) begin
                    // Block average of AVG_N symbols; mean refreshes per block
                    if (cnt_q == lqi_pkg::CNT_FULL - lqi_pkg::CNT_ONE) begin
                        acc_d = lqi_pkg::ACC_ZERO;
                        cnt_d = lqi_pkg::CNT_ZERO;
                        mean_d = block_sum[lqi_pkg::ACC_W-1:lqi_pkg::AVG_SHIFT]; // RULE_01
                    end else begin
                        acc_d = block_sum;
                        cnt_d = cnt_q + lqi_pkg::CNT_ONE;
                    end
                end
                // A symbol landing with frame end is counted but misses this result
                if (frame_end) begin
                    state_d = ST_IDLE;
                    lqi_d = lqi_new; // RULE_05 RULE_07
                    irq_d = 1'b1; // RULE_05 RULE_06
                end
            end
            default: state_d = ST_IDLE;
        endcase
        busy_d = (state_d == ST_RX);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            acc_q <= lqi_pkg::ACC_ZERO;
            cnt_q <= lqi_pkg::CNT_ZERO;
            mean_q <= '0;
            lqi_q <= lqi_pkg::LQI_MIN;
            irq_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            acc_q <= acc_d;
            cnt_q <= cnt_d;
            mean_q <= mean_d;
            lqi_q <= lqi_d;
            irq_q <= irq_d;
            busy_q <= busy_d;
        end
    end

    // Checker-only symbol count, saturating once a whole block has been seen
    always_comb begin
        seen_d = seen_q;
        if (!busy_q && shr_found) begin
            seen_d = lqi_pkg::CNT_ZERO;
        end else if (busy_q && sym_valid && (seen_q != lqi_pkg::CNT_FULL)) begin
            seen_d = seen_q + lqi_pkg::CNT_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            seen_q <= lqi_pkg::CNT_ZERO;
        end else begin
            seen_q <= seen_d;
        end
    end

    assign frame_done_interrupt = irq_q;

    AST_IRQ_PULSE: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
        frame_done_interrupt |=> !frame_done_interrupt)
        else $error("Frame done pulse longer than one cycle");

    AST_LQI_HELD: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
        !frame_done_interrupt |-> $stable(lqi_q))
        else $error("Quality changed outside frame end");

    AST_START: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
        (!busy_q && shr_found) |=> busy_q)
        else $error("No start on sync header");

    AST_END: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
        (busy_q && frame_end) |=> (frame_done_interrupt && !busy_q))
        else $error("Frame end not signalled");

    AST_NO_IRQ_IDLE: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
        !busy_q |=> !frame_done_interrupt)
        else $error("Interrupt without frame");

    AST_LQI_SCALE: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
        frame_done_interrupt |-> lqi_q == $past(lqi_new))
        else $error("Quality not taken from scaler");

    AST_AVG: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
        (busy_q && sym_valid && (cnt_q == lqi_pkg::CNT_FULL - lqi_pkg::CNT_ONE)) |=> (cnt_q == lqi_pkg::CNT_ZERO))
        else $error("Averaging block length wrong");

    AST_MEAN_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
        (busy_q && !sym_valid && !frame_end) |=> $stable(mean_q))
        else $error("Mean moved without symbol");

    AST_FEW_SYMBOLS: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
        (busy_q && frame_end && (seen_q != lqi_pkg::CNT_FULL)) |=> (lqi_q == lqi_pkg::LQI_MIN))
        else $error("Quality reported from less than one block");

    AST_FLOOR: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
        (busy_q && frame_end && (mean_q <= lqi_pkg::CORR_FLOOR)) |=> (lqi_q == lqi_pkg::LQI_MIN))
        else $error("Weak signal not mapped to lowest quality");

    AST_CEILING: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
        (busy_q && frame_end && (&mean_q)) |=> (lqi_q == lqi_pkg::LQI_MAX))
        else $error("Full correlation not mapped to highest quality");

    AST_IRQ_NOT_BUSY: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
        frame_done_interrupt |-> !busy_q)
        else $error("Interrupt while frame still open");

    AST_IRQ_CAUSE: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
        frame_done_interrupt |-> $past(busy_q && frame_end))
        else $error("Interrupt without a frame end");

    AST_FRESH_START: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
        (!busy_q && shr_found) |=> ((cnt_q == lqi_pkg::CNT_ZERO)
            && (acc_q == lqi_pkg::ACC_ZERO) && (mean_q == '0)))
        else $error("Measurement not cleared at start");

    AST_BUSY_KEEPS: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
        (busy_q && !frame_end) |=> busy_q)
        else $error("Measurement dropped before frame end");

    AST_IDLE_QUIET: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
        (!busy_q && !shr_found) |=> !busy_q)
        else $error("Measurement started without sync header");

    AST_IDLE_END_IGNORED: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
        (!busy_q && frame_end) |=> (!frame_done_interrupt && $stable(lqi_q)))
        else $error("Stray frame end acted on");

    AST_CNT_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
        (busy_q && !sym_valid) |=> $stable(cnt_q))
        else $error("Symbol count moved without symbol");

    AST_CNT_RANGE: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
        busy_q |-> (cnt_q < lqi_pkg::CNT_FULL))
        else $error("Symbol count beyond one block");

    AST_MEAN_MID_BLOCK: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
        (busy_q && sym_valid && (cnt_q != lqi_pkg::CNT_FULL - lqi_pkg::CNT_ONE)) |=> $stable(mean_q))
        else $error("Mean moved inside a block");

    AST_ACC_CLEAR: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
        (busy_q && sym_valid && (cnt_q == lqi_pkg::CNT_FULL - lqi_pkg::CNT_ONE)) |=> (acc_q == lqi_pkg::ACC_ZERO))
        else $error("Sum not cleared after a block");

    AST_BUSY_STATE: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
        busy_q == (state_q == ST_RX))
        else $error("Busy flag disagrees with state");

    AST_STATE_ONEHOT: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
        $onehot(state_q))
        else $error("State code not one-hot");

    AST_AFTER_IRQ_HELD: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
        frame_done_interrupt |=> $stable(lqi_q))
        else $error("Quality moved right after frame end");
endmodule : link_quality_estimator
`default_nettype wire

// [tb/rx_path_model.sv]
`timescale 1ns/1ps
`default_nettype none
module rx_path_model (
    // Clock
    input wire logic clk,
    // Receive path toward the estimator
    output logic shr_found,
    output logic sym_valid,
    output logic [lqi_pkg::CORR_W-1:0] sym_corr,
    output logic frame_end
);
    initial begin
        shr_found = 1'b0;
        sym_valid = 1'b0;
        sym_corr = 8'hA5;
        frame_end = 1'b0;
    end
    task automatic send(input logic [7:0] a, input logic [7:0] b, input int n);
        @(negedge clk);
        shr_found = 1'b1;
        @(negedge clk);
        shr_found = 1'b0;
        for (int i = 0; i < n; i++) begin
            sym_valid = 1'b1;
            sym_corr = i[0] ? b : a;
            @(negedge clk);
        end
        sym_valid = 1'b0;
        // Stale data must not look valid, so the line toggles once the symbol is gone
        sym_corr = ~sym_corr;
        frame_end = 1'b1;
        @(negedge clk);
        frame_end = 1'b0;
    endtask : send
    task automatic stray_end();
        frame_end = 1'b1;
        @(negedge clk);
        frame_end = 1'b0;
    endtask : stray_end
    task automatic stray_sync();
        shr_found = 1'b1;
        @(negedge clk);
        shr_found = 1'b0;
    endtask : stray_sync
endmodule : rx_path_model
`default_nettype wire

// [tb/link_quality_estimator_test.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; $display("CHECK FAILED %0t bad value", $time); end end
module link_quality_estimator_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic shr_found, sym_valid, frame_end, frame_done_interrupt, busy_q;
    logic [7:0] sym_corr, lqi_q;
    int fails = 0;
    int comparisons = 0;
    always #2 clk = ~clk;
    rx_path_model rx_path_model_i (.clk(clk), .shr_found(shr_found), .sym_valid(sym_valid),
        .sym_corr(sym_corr), .frame_end(frame_end));
    link_quality_estimator link_quality_estimator_i (.clk(clk), .rst_n(rst_n),
        .shr_found(shr_found), .sym_valid(sym_valid), .sym_corr(sym_corr),
        .frame_end(frame_end), .lqi_q(lqi_q), .frame_done_interrupt(frame_done_interrupt),
        .busy_q(busy_q));
    // Alternating symbols a and b: the block mean is their midpoint
    task automatic frame(input int a, input int b, input int n);
        int m = (a + b) / 2 - 'h40;
        logic [7:0] e = (n < 8 || m < 0) ? 8'h00 : (m > 'h3F ? 8'hFF : 8'(m * 4));
        rx_path_model_i.send(8'(a), 8'(b), n);
        `CHK(frame_done_interrupt, 1'b1)
        `CHK(lqi_q, e)
        `CHK(busy_q, 1'b0)
        @(negedge clk);
        `CHK(frame_done_interrupt, 1'b0)
        `CHK(lqi_q, e)
        repeat (3) @(negedge clk);
        `CHK(lqi_q, e)
    endtask : frame
    task automatic limits_test();
        frame('h20, 'h20, 8);
        frame('h41, 'h41, 8);
        frame('h7F, 'h81, 8);
        frame('hFF, 'hFF, 8);
    endtask : limits_test
    // A sync header inside a frame must not restart the measurement
    task automatic restart_test();
        fork
            frame('h48, 'h58, 8);
            begin
                repeat (4) @(negedge clk);
                rx_path_model_i.stray_sync();
                `CHK(busy_q, 1'b1)
            end
        join
    endtask : restart_test
    // Reset in mid-frame drops the measurement and the stored result
    task automatic reset_test();
        fork
            rx_path_model_i.send(8'hFF, 8'hFF, 8);
            begin
                repeat (4) @(negedge clk);
                rst_n = 1'b0;
                repeat (2) @(negedge clk);
                `CHK(busy_q, 1'b0)
                rst_n = 1'b1;
            end
        join
        `CHK(frame_done_interrupt, 1'b0)
        `CHK(lqi_q, 8'h00)
        frame('h48, 'h58, 8);
    endtask : reset_test
    task automatic stray_test();
        rx_path_model_i.stray_end();
        `CHK(frame_done_interrupt, 1'b0)
        `CHK(lqi_q, 8'hFF)
    endtask : stray_test
    task automatic complete_run();
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        #20000;
        fails++;
        complete_run();
    end
    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        `CHK(lqi_q, 8'h00)
        frame('h48, 'h58, 8);
        frame('h30, 'h70, 16);
        frame('hFF, 'hFF, 7);
        limits_test();
        stray_test();
        restart_test();
        reset_test();
        complete_run();
    end
endmodule : link_quality_estimator_test
`default_nettype wire
